// *** rtl/pnp_pkg.sv ***
// constants, register indexes and the card state type for the plug and play card control
// assumes nothing: definitions only, shared by every design file
package pnp_pkg;
  // auto-configuration port addresses on a 12-bit isa decode
  localparam logic [11:0] ADDR_PORT = 12'h279;
  localparam logic [11:0] WDATA_PORT = 12'hA79;
  localparam logic [1:0] RPORT_HI = 2'h0; // read port address bits 11:10
  localparam logic [1:0] RPORT_LO = 2'h3; // read port address bits 1:0
  // card control register indexes
  localparam logic [7:0] IDX_RD_PORT = 8'h00;
  localparam logic [7:0] IDX_ISOLATE = 8'h01;
  localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
  localparam logic [7:0] IDX_WAKE = 8'h03;
  localparam logic [7:0] IDX_RES_DATA = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] IDX_CARD_HANDLE = 8'h06;
  localparam logic [7:0] IDX_LDEV = 8'h07;
  // config control command bit positions
  localparam int CC_LDEV_BIT = 0;
  localparam int CC_WAITKEY_BIT = 1;
  localparam int CC_HANDLE_BIT = 2;
  // values after reset
  localparam logic [7:0] HANDLE_RST = 8'h00;
  localparam logic [7:0] RD_PORT_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [7:0] LDEV_VAL = 8'h00; // single logical device
  // initiation key: seed and length of the lfsr sequence
  localparam logic [7:0] KEY_SEED = 8'h6A;
  localparam logic [5:0] KEY_LAST = 6'h1F; // count of the 32nd byte
  // isolation
  localparam logic [6:0] ID_BITS = 7'h48; // 72 identifier bits
  localparam logic [7:0] PAT_ONE = 8'h55;
  localparam logic [7:0] PAT_TWO = 8'hAA;
  localparam logic [1:0] SENSE_ONE = 2'h1;
  localparam logic [1:0] SENSE_TWO = 2'h2;
  // resource storage
  localparam int STORE_AW = 10;
  localparam logic [STORE_AW-1:0] STORE_PTR_RST = 10'h000;
  typedef enum logic [1:0] {ST_WAIT_KEY, ST_SLEEP, ST_ISOLATE, ST_CONFIG} card_state_t;
endpackage

// *** rtl/pnp_key_detect.sv ***
// initiation key detector: follows writes to the address port against the lfsr sequence
// assumes one-cycle write strobes from already synchronised bus signals
`timescale 1ns/1ns
module pnp_key_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic armed_i,
  input wire logic wr_i,
  input wire logic [7:0] data_i,
  output logic match_o
);
  // next key byte: shift right, feedback is the xor of the two low bits
  function automatic logic [7:0] key_next(input logic [7:0] cur);
    key_next = {cur[1] ^ cur[0], cur[7:1]};
  endfunction

  logic [7:0] expect_r; // byte the next write must carry
  logic [5:0] count_r; // bytes matched so far
  logic match_r;
  wire hit = (data_i == expect_r);
  wire last = (count_r == pnp_pkg::KEY_LAST);
  // a stray byte may itself be the first key byte, so restart from it
  wire restart_one = (data_i == pnp_pkg::KEY_SEED);

  //////////////////////////////////////////////////////////////////////////////
  // sequence tracker
  always_ff @(posedge clk_i) begin
    if (rst_i || !armed_i) begin
      expect_r <= pnp_pkg::KEY_SEED;
      count_r <= 6'h00;
      match_r <= 1'b0;
    end else begin
      match_r <= wr_i && hit && last; // RULE23
      if (wr_i && hit && !last) begin
        expect_r <= key_next(expect_r);
        count_r <= count_r + 6'h01;
      end else if (wr_i && !hit && restart_one) begin
        expect_r <= key_next(pnp_pkg::KEY_SEED);
        count_r <= 6'h01;
      end else if (wr_i) begin
        // any other write breaks the sequence
        expect_r <= pnp_pkg::KEY_SEED;
        count_r <= 6'h00;
      end
    end
  end

  assign match_o = match_r;

  key_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
    match_r |-> $past(count_r) == 6'h1F && $past(wr_i))
    else $error("key match without 32 consecutive bytes");
endmodule

// *** rtl/pnp_resource_fetch.sv ***
// resource data fetcher: reads bytes from slow storage one at a time, flags when one is ready
// assumes storage answers a held request with a one-cycle ack on the same clock
`timescale 1ns/1ns
module pnp_resource_fetch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic take_i,
  output logic ready_o,
  output logic [7:0] byte_o,
  output logic [pnp_pkg::STORE_AW-1:0] store_addr_o,
  output logic store_req_o,
  input wire logic [7:0] store_data_i,
  input wire logic store_ack_i
);
  logic [pnp_pkg::STORE_AW-1:0] ptr_r; // storage pointer
  logic req_r;
  logic ready_r;
  logic [7:0] byte_r;
  wire consume = take_i && ready_r;

  //////////////////////////////////////////////////////////////////////////////
  // pointer, request and ready flag
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      ptr_r <= pnp_pkg::STORE_PTR_RST; // RULE15
      req_r <= 1'b1;
      ready_r <= 1'b0;
      byte_r <= 8'h00;
    end else if (consume) begin
      // byte handed out: move on and fetch the next
      ptr_r <= ptr_r + 10'h001; // RULE16
      req_r <= 1'b1;
      ready_r <= 1'b0;
    end else if (req_r && store_ack_i) begin
      byte_r <= store_data_i;
      req_r <= 1'b0;
      ready_r <= 1'b1; // RULE17
    end
  end

  assign ready_o = ready_r;
  assign byte_o = byte_r;
  assign store_addr_o = ptr_r;
  assign store_req_o = req_r;

  res_take_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
    consume && !restart_i |=> !ready_r && req_r && ptr_r == $past(ptr_r) + 10'h001)
    else $error("resource take did not clear ready and advance");
endmodule

// *** rtl/pnp_card_control.sv ***
// plug and play card control: isa port decode, card states, isolation and card registers
// assumes raw isa pins on CLK_I's board, serial id and storage on the CLK_I domain
//
// Function
// [RULE1] host reads 72 pairs, 55h/AAh is one
// [RULE2] host checks checksum over first 64 bits
// [RULE3] first failure means read port conflict, relocate
// [RULE4] later failure means no more cards remain
// [RULE5] host waits 1 ms, then 250 ms per pair; testbench waits 1 ms, then reads pairs back to back
// [RULE6] hardware reset: key wait, handle cleared
// [RULE7] wait-key command returns card to key wait
// [RULE8] index 0 write sets read port bits 9:2
// [RULE9] isolation read compares one identifier bit
// [RULE10] control bit 0 resets logical device, keeps handle
// [RULE11] control bit 1 returns to key wait
// [RULE12] control bit 2 clears card handle
// [RULE13] control register write-only, bits self-clear
// [RULE14] matching wake: zero isolates, nonzero configures
// [RULE15] any wake write rewinds storage pointer
// [RULE16] resource read returns next byte
// [RULE17] status bit 0 flags byte ready
// [RULE18] index 6 write sets card handle
// [RULE19] logical device index reads zero
// [RULE20] only two memory descriptors, none third
// [RULE21] one bit drives 55h then AAh, else senses
// [RULE22] identifier shifts out bit 0 first
// [RULE23] ports enabled only after full key
// [RULE24] address port selects register index
// [RULE25] commands in wrong state or mismatch ignored
`timescale 1ns/1ns
module pnp_card_control (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [11:0] SA_I,
  input wire logic [7:0] SD_I,
  input wire logic IOR_N_I,
  input wire logic IOW_N_I,
  input wire logic AEN_I,
  output logic [7:0] SD_O,
  output logic SD_OE_O,
  input wire logic [71:0] SERIAL_ID_I,
  output logic [pnp_pkg::STORE_AW-1:0] STORE_ADDR_O,
  output logic STORE_REQ_O,
  input wire logic [7:0] STORE_DATA_I,
  input wire logic STORE_ACK_I,
  output logic LDEV_RESET_O,
  output logic [1:0] CARD_STATE_O,
  output logic [7:0] CARD_HANDLE_O
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic [11:0] sa_s1, sa_s2;
  logic [7:0] sd_s1, sd_s2;
  logic ior_s1, ior_s2, iow_s1, iow_s2, aen_s1, aen_s2;
  logic ior_d, iow_d; // delayed stage two, for edge detection

  // two flops on every bus pin; adds ~80 ns of latency to each strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sa_s1 <= 12'h000;
      sa_s2 <= 12'h000;
      sd_s1 <= 8'h00;
      sd_s2 <= 8'h00;
      {ior_s1, ior_s2, ior_d} <= 3'h7;
      {iow_s1, iow_s2, iow_d} <= 3'h7;
      {aen_s1, aen_s2} <= 2'h3;
    end else begin
      sa_s1 <= SA_I;
      sa_s2 <= sa_s1;
      sd_s1 <= SD_I;
      sd_s2 <= sd_s1;
      {ior_s1, ior_s2, ior_d} <= {IOR_N_I, ior_s1, ior_s2};
      {iow_s1, iow_s2, iow_d} <= {IOW_N_I, iow_s1, iow_s2};
      {aen_s1, aen_s2} <= {AEN_I, aen_s1};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state and registers
  pnp_pkg::card_state_t state_r, state_nxt;
  logic [7:0] index_r; // last address port value
  logic [7:0] rd_port_r; // read port address bits 9:2
  logic [7:0] handle_r; // card handle
  logic [6:0] id_pos_r; // identifier bit under test
  logic phase_r; // 0 first read of a pair, 1 second
  logic sense_r; // another card seen on the first read
  logic rd_active_r; // a read of ours is in progress
  logic [7:0] sd_r;
  logic sd_oe_r;
  logic ldev_rst_r;

  //////////////////////////////////////////////////////////////////////////////
  // strobe and address decode
  wire wr_stb = iow_d && !iow_s2 && !aen_s2; // write taken at strobe start
  wire rd_start = ior_d && !ior_s2 && !aen_s2;
  wire rd_end = !ior_d && ior_s2; // bus data sampled here, still before release
  wire hit_addr = (sa_s2 == pnp_pkg::ADDR_PORT);
  wire hit_wdata = (sa_s2 == pnp_pkg::WDATA_PORT);
  wire hit_rport = (sa_s2 == {pnp_pkg::RPORT_HI, rd_port_r, pnp_pkg::RPORT_LO});
  wire ports_en = (state_r != pnp_pkg::ST_WAIT_KEY);
  wire in_iso = (state_r == pnp_pkg::ST_ISOLATE);
  wire in_cfg = (state_r == pnp_pkg::ST_CONFIG);
  wire in_sleep = (state_r == pnp_pkg::ST_SLEEP);
  wire idx_wr = wr_stb && hit_addr && ports_en;
  wire reg_wr = wr_stb && hit_wdata && ports_en;
  wire wr_rport = reg_wr && index_r == pnp_pkg::IDX_RD_PORT && (in_iso || in_cfg);
  wire wr_cc = reg_wr && index_r == pnp_pkg::IDX_CFG_CTRL;
  wire wr_wake = reg_wr && index_r == pnp_pkg::IDX_WAKE;
  wire wr_handle = reg_wr && index_r == pnp_pkg::IDX_CARD_HANDLE && (in_iso || in_cfg);
  wire wake_hit = wr_wake && in_sleep && sd_s2 == handle_r;
  wire rd_hit = rd_start && hit_rport && ports_en;

  //////////////////////////////////////////////////////////////////////////////
  // key detector and resource fetcher
  logic key_match;
  logic res_ready;
  logic [7:0] res_byte;

  pnp_key_detect u_key (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .armed_i(!ports_en),
    .wr_i(wr_stb && hit_addr),
    .data_i(sd_s2),
    .match_o(key_match)
  );

  wire res_take = rd_end && rd_active_r && in_cfg && index_r == pnp_pkg::IDX_RES_DATA;

  pnp_resource_fetch u_res (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .restart_i(wr_wake), // RULE15
    .take_i(res_take), // RULE16
    .ready_o(res_ready),
    .byte_o(res_byte),
    .store_addr_o(STORE_ADDR_O),
    .store_req_o(STORE_REQ_O),
    .store_data_i(STORE_DATA_I),
    .store_ack_i(STORE_ACK_I)
  );

  //////////////////////////////////////////////////////////////////////////////
  // isolation decode
  wire id_live = (id_pos_r < pnp_pkg::ID_BITS); // stays quiet after the last bit
  wire cur_bit = id_live && SERIAL_ID_I[id_pos_r]; // RULE22
  wire iso_sel = in_iso && id_live && index_r == pnp_pkg::IDX_ISOLATE; // RULE9
  wire iso_end = rd_end && rd_active_r && iso_sel;
  wire lost = !cur_bit && sense_r && sd_s2[1:0] == pnp_pkg::SENSE_TWO; // RULE21
  wire [7:0] iso_data = phase_r ? pnp_pkg::PAT_TWO : pnp_pkg::PAT_ONE; // RULE21

  //////////////////////////////////////////////////////////////////////////////
  // read data decode; indexes above the card block, descriptor 2 among them, float
  wire cfg_readable = in_cfg && index_r >= pnp_pkg::IDX_RES_DATA
                      && index_r <= pnp_pkg::IDX_LDEV; // RULE20
  wire [7:0] cfg_data = (index_r == pnp_pkg::IDX_RES_DATA) ? res_byte :
                        (index_r == pnp_pkg::IDX_STATUS) ? {7'h00, res_ready} : // RULE17
                        (index_r == pnp_pkg::IDX_CARD_HANDLE) ? handle_r :
                        pnp_pkg::LDEV_VAL; // RULE19
  wire drive_now = (iso_sel && cur_bit) || cfg_readable;
  wire [7:0] drive_data = cfg_readable ? cfg_data : iso_data;

  //////////////////////////////////////////////////////////////////////////////
  // next card state; reset and key wait win over every other command
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pnp_pkg::ST_WAIT_KEY: begin
        if (key_match) begin
          state_nxt = pnp_pkg::ST_SLEEP; // RULE23
        end
      end
      pnp_pkg::ST_SLEEP: begin
        if (wake_hit) begin
          // zero data wakes into isolation, otherwise into config
          state_nxt = (sd_s2 == 8'h00) ? pnp_pkg::ST_ISOLATE : pnp_pkg::ST_CONFIG; // RULE14
        end
      end
      pnp_pkg::ST_ISOLATE: begin
        if (wr_handle) begin
          state_nxt = pnp_pkg::ST_CONFIG; // RULE18
        end else if (iso_end && phase_r && lost) begin
          state_nxt = pnp_pkg::ST_SLEEP; // lost this round, waits for a later one
        end
      end
      pnp_pkg::ST_CONFIG: begin
        state_nxt = pnp_pkg::ST_CONFIG; // RULE25
      end
      default: begin
        state_nxt = pnp_pkg::ST_WAIT_KEY;
      end
    endcase
    if (wr_cc && sd_s2[pnp_pkg::CC_WAITKEY_BIT]) begin
      state_nxt = pnp_pkg::ST_WAIT_KEY; // RULE7 RULE11
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register, handle, read port and index
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= pnp_pkg::ST_WAIT_KEY; // RULE6
      handle_r <= pnp_pkg::HANDLE_RST; // RULE6
      rd_port_r <= pnp_pkg::RD_PORT_RST;
      index_r <= pnp_pkg::INDEX_RST;
    end else begin
      state_r <= state_nxt;
      if (wr_cc && sd_s2[pnp_pkg::CC_HANDLE_BIT]) begin
        handle_r <= pnp_pkg::HANDLE_RST; // RULE12
      end else if (wr_handle) begin
        handle_r <= sd_s2; // RULE18
      end
      if (wr_rport) begin
        rd_port_r <= sd_s2; // RULE8
      end
      if (idx_wr) begin
        index_r <= sd_s2; // RULE24
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // isolation bit walk
  always_ff @(posedge CLK_I) begin
    if (RST_I || !in_iso) begin
      id_pos_r <= 7'h00;
      phase_r <= 1'b0;
      sense_r <= 1'b0;
    end else if (iso_end && !phase_r) begin
      phase_r <= 1'b1;
      sense_r <= sd_s2[1:0] == pnp_pkg::SENSE_ONE; // RULE21
    end else if (iso_end) begin
      phase_r <= 1'b0;
      sense_r <= 1'b0;
      id_pos_r <= id_pos_r + 7'h01; // RULE22
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data bus driver: held from read start to strobe release
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sd_r <= 8'h00;
      sd_oe_r <= 1'b0;
      rd_active_r <= 1'b0;
    end else if (rd_hit) begin
      sd_r <= drive_data;
      sd_oe_r <= drive_now; // RULE21
      rd_active_r <= 1'b1;
    end else if (ior_s2) begin
      sd_oe_r <= 1'b0;
      rd_active_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // logical device reset pulse; control bits are never stored
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ldev_rst_r <= 1'b0;
    end else begin
      ldev_rst_r <= wr_cc && sd_s2[pnp_pkg::CC_LDEV_BIT]; // RULE10 RULE13
    end
  end

  assign SD_O = sd_r;
  assign SD_OE_O = sd_oe_r;
  assign LDEV_RESET_O = ldev_rst_r;
  assign CARD_STATE_O = state_r;
  assign CARD_HANDLE_O = handle_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  hw_reset_a: assert property (@(posedge CLK_I) // RULE6
    RST_I |=> state_r == pnp_pkg::ST_WAIT_KEY && handle_r == 8'h00)
    else $error("reset did not reach key wait with cleared handle");
  cc_waitkey_a: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE11
    wr_cc && sd_s2[1] |=> state_r == pnp_pkg::ST_WAIT_KEY && handle_r == $past(handle_r)
      || $past(sd_s2[2]))
    else $error("wait key command failed or lost the handle");
  cc_handle_clr_a: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE12
    wr_cc && sd_s2[2] |=> handle_r == 8'h00)
    else $error("handle not cleared by control write");
  ldev_pulse_a: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE13
    wr_cc && sd_s2[0] |=> LDEV_RESET_O ##1 !LDEV_RESET_O)
    else $error("logical device reset not a single pulse");
  wake_cfg_a: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE14
    wake_hit && sd_s2 != 8'h00 |=> state_r == pnp_pkg::ST_CONFIG)
    else $error("matching wake did not enter config");
  wake_miss_a: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE25
    wr_wake && sd_s2 != handle_r |=> $stable(state_r))
    else $error("mismatched wake changed the card state");
  iso_one_a: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE21
    rd_hit && iso_sel && cur_bit && !phase_r |=> SD_OE_O && SD_O == 8'h55)
    else $error("first isolation read did not drive 55h");
  ldev_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE19
    rd_hit && in_cfg && index_r == 8'h07 |=> SD_OE_O && SD_O == 8'h00)
    else $error("logical device index did not read zero");
  rd_port_a: assert property (@(posedge CLK_I) disable iff (RST_I) // RULE8
    wr_rport |=> rd_port_r == $past(sd_s2))
    else $error("read port address not loaded");
endmodule

// *** verif/pnp_store_model.sv ***
// slow resource storage model sitting behind the card's storage port
// assumes a request held until ack; content of byte a is a[7:0] xor 3Ch
`timescale 1ns/1ns
module pnp_store_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] addr_i,
  input wire logic req_i,
  output logic [7:0] data_o,
  output logic ack_o
);
  int cnt; // cycles waited on the current request
  logic slow; // alternates prompt and slow answers
  logic rest; // one idle cycle after each ack, so a held request is not served twice
  ////////////////////////////////////////////////////////////////////////////////
  // answer after 1 or 6 cycles; data churns outside the ack so stale bytes never match
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i) begin
      cnt <= 0;
      slow <= 1'b0;
      rest <= 1'b0;
      data_o <= 8'h5A;
    end else if (rest) begin
      rest <= 1'b0;
    end else if (req_i) begin
      if (cnt == (slow ? 6 : 1)) begin
        ack_o <= 1'b1;
        data_o <= addr_i[7:0] ^ 8'h3C;
        cnt <= 0;
        slow <= ~slow;
        rest <= 1'b1;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule

// *** verif/testbench.sv ***
// testbench for the card control: plays the isa host and its configuration software
// assumes the storage model; bus inputs change on the falling clock edge
`timescale 1ns/1ns
module testbench;
  logic clk;
  logic rst;
  logic [11:0] sa;
  logic ior_n;
  logic iow_n;
  logic aen; // dma cycle marker
  logic [7:0] drv; // host write data
  logic drv_en;
  logic [7:0] oc_val; // a second card on the bus
  logic oc_en;
  logic [7:0] sd_o;
  logic sd_oe;
  logic [7:0] sd_bus;
  logic [71:0] serial_id;
  logic [9:0] st_addr;
  logic st_req;
  logic [7:0] st_data;
  logic st_ack;
  logic ldev_rst;
  logic [1:0] state;
  logic [7:0] handle;
  int err_count;
  int total_checks;
  int ldev_seen;
  logic [11:0] rport;
  logic [71:0] rx;
  logic oe_a;
  logic oe_b;
  logic [7:0] d_a;
  logic [7:0] d_b;
  // data lines have pull-ups: released bus reads ffh
  assign sd_bus = drv_en ? drv : (oc_en ? oc_val : (sd_oe ? sd_o : 8'hFF));
  ////////////////////////////////////////////////////////////////////////////////
  pnp_card_control u_pnp_card_control (.CLK_I(clk), .RST_I(rst), .SA_I(sa), .SD_I(sd_bus),
    .IOR_N_I(ior_n), .IOW_N_I(iow_n), .AEN_I(aen), .SD_O(sd_o), .SD_OE_O(sd_oe),
    .SERIAL_ID_I(serial_id), .STORE_ADDR_O(st_addr), .STORE_REQ_O(st_req),
    .STORE_DATA_I(st_data), .STORE_ACK_I(st_ack), .LDEV_RESET_O(ldev_rst),
    .CARD_STATE_O(state), .CARD_HANDLE_O(handle));
  pnp_store_model u_pnp_store_model (.clk_i(clk), .rst_i(rst), .addr_i(st_addr),
    .req_i(st_req), .data_o(st_data), .ack_o(st_ack));
  ////////////////////////////////////////////////////////////////////////////////
  // key lfsr and checksum: shift right, new top bit from the two low bits, xored with the data bit for the checksum
  function automatic logic [7:0] key_next(input logic [7:0] k);
    return {k[0] ^ k[1], k[7:1]};
  endfunction
  function automatic logic [7:0] cks(input logic [63:0] v);
    logic [7:0] l;
    l = 8'h6A;
    for (int i = 0; i < 64; i++) l = {l[0] ^ l[1] ^ v[i], l[7:1]};
    return l;
  endfunction
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_card(input logic [1:0] st, input logic [7:0] h);
    chk("card state", {6'h00, st}, {6'h00, state});
    chk("card handle", h, handle);
  endtask
  // strobes held four cycles low and four high, well past the three-cycle minimum
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    sa = a;
    drv = d;
    drv_en = 1'b1;
    iow_n = 1'b0;
    repeat (4) @(negedge clk);
    iow_n = 1'b1;
    repeat (4) @(negedge clk);
    drv_en = 1'b0;
  endtask
  task automatic rd(output logic oe, output logic [7:0] d);
    @(negedge clk);
    sa = rport;
    ior_n = 1'b0;
    repeat (4) @(negedge clk);
    oe = sd_oe;
    d = sd_bus;
    ior_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
    wr(pnp_pkg::ADDR_PORT, i);
    wr(pnp_pkg::WDATA_PORT, d);
  endtask
  task automatic rd_reg(input logic [7:0] i, output logic oe, output logic [7:0] d);
    wr(pnp_pkg::ADDR_PORT, i);
    rd(oe, d);
  endtask
  task automatic send_key(input int n);
    logic [7:0] k;
    k = 8'h6A;
    for (int i = 0; i < n; i++) begin
      wr(pnp_pkg::ADDR_PORT, k);
      k = key_next(k);
    end
  endtask
  // poll status bit 0 under a bound, then take one resource byte
  task automatic get_res(input logic [7:0] exp);
    logic oe;
    logic [7:0] d;
    d = 8'h00;
    wr(pnp_pkg::ADDR_PORT, pnp_pkg::IDX_STATUS);
    for (int n = 0; n < 20 && d[0] !== 1'b1; n++) rd(oe, d);
    chk("status", 8'h01, d);
    if (d !== 8'h01) give_verdict();
    rd_reg(pnp_pkg::IDX_RES_DATA, oe, d);
    chk("resource byte", exp, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock, pulse counter and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (ldev_rst === 1'b1) ldev_seen++;
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    $display("[ERR] run length expected finish seen timeout");
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_count = 0;
    total_checks = 0;
    ldev_seen = 0;
    rst = 1'b1;
    sa = 12'h000;
    ior_n = 1'b1;
    iow_n = 1'b1;
    aen = 1'b0;
    drv = 8'h00;
    drv_en = 1'b0;
    oc_val = 8'h00;
    oc_en = 1'b0;
    rport = 12'h20B;
    serial_id[63:0] = 64'h1234_5678_9ABC_DEF0; // bit 0 is zero for the losing case
    serial_id[71:64] = cks(serial_id[63:0]);
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_card(pnp_pkg::ST_WAIT_KEY, 8'h00);
    // a wake before the key must be ignored
    wr_reg(pnp_pkg::IDX_WAKE, 8'h00);
    send_key(31);
    chk_card(pnp_pkg::ST_WAIT_KEY, 8'h00);
    send_key(32);
    chk_card(pnp_pkg::ST_SLEEP, 8'h00);
    wr_reg(pnp_pkg::IDX_WAKE, 8'h00);
    chk_card(pnp_pkg::ST_ISOLATE, 8'h00);
    wr_reg(pnp_pkg::IDX_RD_PORT, 8'h80);
    rport = {pnp_pkg::RPORT_HI, 8'h80, pnp_pkg::RPORT_LO};
    // another card drives a one where ours holds a zero: ours loses
    wr(pnp_pkg::ADDR_PORT, pnp_pkg::IDX_ISOLATE);
    oc_en = 1'b1;
    oc_val = 8'h55;
    rd(oe_a, d_a);
    oc_val = 8'hAA;
    rd(oe_b, d_b);
    oc_en = 1'b0;
    chk_bit("losing drive", 1'b0, oe_a | oe_b);
    chk_card(pnp_pkg::ST_SLEEP, 8'h00);
    wr_reg(pnp_pkg::IDX_WAKE, 8'h00);
    chk_card(pnp_pkg::ST_ISOLATE, 8'h00);
    // a read at an undecoded port shows no pattern: software relocates to the top address
    rport = 12'h20B;
    rd(oe_a, d_a);
    chk("conflict probe", 8'hFF, d_a);
    wr_reg(pnp_pkg::IDX_RD_PORT, 8'hFF);
    rport = 12'h3FF;
    wr(pnp_pkg::ADDR_PORT, pnp_pkg::IDX_ISOLATE);
    repeat (25000) @(negedge clk);
    // pair spacing kept short: the identifier comes from a static port, not slow storage
    for (int i = 0; i < 72; i++) begin
      rd(oe_a, d_a);
      rd(oe_b, d_b);
      rx[i] = (d_a === 8'h55) && (d_b === 8'hAA);
      chk("first read", serial_id[i] ? 8'h55 : 8'hFF, d_a);
      chk("second read", serial_id[i] ? 8'hAA : 8'hFF, d_b);
      chk_bit("isolation drive", serial_id[i], oe_a);
    end
    chk("checksum", cks(rx[63:0]), rx[71:64]);
    for (int b = 0; b < 8; b++) chk("id byte", serial_id[8*b +: 8], rx[8*b +: 8]);
    wr_reg(pnp_pkg::IDX_CARD_HANDLE, 8'h05);
    chk_card(pnp_pkg::ST_CONFIG, 8'h05);
    wr(pnp_pkg::ADDR_PORT, pnp_pkg::IDX_ISOLATE);
    rd(oe_a, d_a);
    rd(oe_b, d_b);
    chk_bit("no further card", 1'b0, oe_a | oe_b);
    rd_reg(pnp_pkg::IDX_CARD_HANDLE, oe_a, d_a);
    chk("handle read", 8'h05, d_a);
    // cycles with aen high belong to dma, so the card must not take them
    aen = 1'b1;
    wr_reg(pnp_pkg::IDX_CARD_HANDLE, 8'h09);
    aen = 1'b0;
    chk_card(pnp_pkg::ST_CONFIG, 8'h05);
    rd_reg(pnp_pkg::IDX_LDEV, oe_a, d_a);
    chk("device index", pnp_pkg::LDEV_VAL, d_a);
    rd_reg(pnp_pkg::IDX_RD_PORT, oe_a, d_a);
    chk_bit("port locator read", 1'b0, oe_a);
    rd_reg(pnp_pkg::IDX_CFG_CTRL, oe_a, d_a);
    chk_bit("control read", 1'b0, oe_a);
    for (int k = 0; k < 3; k++) get_res(8'(k) ^ 8'h3C);
    wr_reg(pnp_pkg::IDX_CFG_CTRL, 8'h01);
    chk("device reset pulses", 8'h01, 8'(ldev_seen));
    chk_card(pnp_pkg::ST_CONFIG, 8'h05);
    wr_reg(pnp_pkg::IDX_CFG_CTRL, 8'h04);
    chk_card(pnp_pkg::ST_CONFIG, 8'h00);
    chk("device reset pulses", 8'h01, 8'(ldev_seen));
    wr_reg(pnp_pkg::IDX_CARD_HANDLE, 8'h07);
    wr_reg(pnp_pkg::IDX_CFG_CTRL, 8'h02);
    chk_card(pnp_pkg::ST_WAIT_KEY, 8'h07);
    send_key(32);
    chk_card(pnp_pkg::ST_SLEEP, 8'h07);
    wr_reg(pnp_pkg::IDX_WAKE, 8'h03);
    chk_card(pnp_pkg::ST_SLEEP, 8'h07);
    wr_reg(pnp_pkg::IDX_WAKE, 8'h07);
    chk_card(pnp_pkg::ST_CONFIG, 8'h07);
    get_res(8'h3C);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_card(pnp_pkg::ST_WAIT_KEY, 8'h00);
    chk("store pointer", 8'h00, st_addr[7:0]);
    give_verdict();
  end
endmodule
